// ==== common/crbm_cfg_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// carries the latched configuration between the capture and the top
interface crbm_cfg_if;
  logic [1:0] boot_src;
  logic       satellite;
  logic       alt_base;
  logic       cold_active;
  modport capt (output boot_src, output satellite, output alt_base, output cold_active);
  modport user (input boot_src, input satellite, input alt_base, input cold_active);
endinterface : crbm_cfg_if
`default_nettype wire

// ==== common/crbm_pkg.sv ====
// What this block does
// - a two-bit boot-source strap is decoded after capture: 00 local boot, 01 bus boot (satellite role only), 10 reserved.
// - with strap 11 the local memory bus and serial prom bus float while cold reset is held and until the straps are captured.
// - in bus-boot mode the device leaves reset on cold reset or bus reset and fetches boot code over the bus.
// - with strap 00 boot code comes through the local memory controller.
// - the non-boot initialisation option moves the internal register base from 1800_0000 to 1900_0000.
// - a role strap sampled at cold reset gives satellite role at 1 and host role at 0.
// - in host role the cpu may write every bus configuration register, and software sets them all.
// - in satellite role with bus boot the read-only configuration registers load from a serial prom.
// - all straps are latched just after cold reset is released and the latched values are used afterwards.
// - in satellite role a bus reset resets the bus logic and warm resets the device; in host role only the bus logic.
package crbm_pkg;
  // ==========================================================================
  // boot source encodings
  localparam logic [1:0] BOOT_LOCAL    = 2'h0;
  localparam logic [1:0] BOOT_BUS      = 2'h1;
  localparam logic [1:0] BOOT_RESERVED = 2'h2;
  localparam logic [1:0] BOOT_FLOAT    = 2'h3;
  // ==========================================================================
  // role strap values and reset values
  localparam logic       ROLE_SATELLITE = 1'h1;
  localparam logic       ROLE_HOST      = 1'h0;
  localparam logic [1:0] BOOT_RST       = BOOT_LOCAL;
  localparam logic       ROLE_RST       = ROLE_HOST;
  // ==========================================================================
  // register base choices
  localparam logic [31:0] REG_BASE_STD = 32'h1800_0000;
  localparam logic [31:0] REG_BASE_ALT = 32'h1900_0000;
  // ==========================================================================
  // timing
  localparam int CLK_MHZ         = 100;
  localparam int COLD_MIN_MS     = 120;
  localparam int COLD_MIN_CYCLES = COLD_MIN_MS * 1000 * CLK_MHZ;
  localparam int CNT_W           = 24;
  // ==========================================================================
  // configuration load states
  typedef enum logic [1:0] {
    CRBM_IDLE = 2'b00,
    CRBM_LOAD = 2'b01,
    CRBM_DONE = 2'b10
  } crbm_state_e;
endpackage

// ==== tb/crbm_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module crbm_partner
  import crbm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [1:0] boot_i,
  input  wire logic       role_i,
  input  wire logic       base_i,
  input  wire logic       bad_i,
  input  wire logic       brst_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       load_i,
  output var  logic [1:0] boot_o,
  output var  logic       role_o,
  output var  logic       base_o,
  output var  logic       brst_b_o,
  output var  logic       done_o
);
  logic [3:0] cnt_ff;
  initial
  begin
    {boot_o, role_o, base_o, done_o, cnt_ff} = '0;
    brst_b_o = 1'b1;
  end
  // ==========
  // straps: bus boot comes with satellite role unless told to break it
  always @(posedge clk_i)
  begin
    boot_o   <= boot_i;
    role_o   <= (boot_i == BOOT_BUS && !bad_i) ? ROLE_SATELLITE : role_i;
    base_o   <= base_i;
    brst_b_o <= !brst_i;
  end
  // ==========
  // serial prom answers after dly_i + 1 cycles of load
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (!load_i || done_o)
      cnt_ff <= 4'h0;
    else if (cnt_ff == dly_i)
      done_o <= 1'b1;
    else
      cnt_ff <= cnt_ff + 4'h1;
  end
endmodule // crbm_partner
`default_nettype wire

// ==== tb/crbm_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module crbm_top_tb;
  import crbm_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, role_q = 1'b0, base_q = 1'b0, bad_q = 1'b0, brst_q = 1'b0;
  logic [1:0]  boot_q = 2'h0, boot_s, e_boot;
  logic [3:0]  dly_q = 4'h0;
  logic [16:0] rnd = 17'h12372;
  logic [31:0] e_base, base;
  logic        e_sat, role_s, base_s, brst_b, done;
  logic        lflt, pflt, blocal, bbus, bres, sat, wren, load, ready, blrst, warm, run;
  int          fails = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  crbm_partner u_partner (.clk_i(clk), .boot_i(boot_q), .role_i(role_q), .base_i(base_q), .bad_i(bad_q),
    .brst_i(brst_q), .dly_i(dly_q), .load_i(load), .boot_o(boot_s), .role_o(role_s), .base_o(base_s),
    .brst_b_o(brst_b), .done_o(done));
  crbm_top u_dut (.CLK_I(clk), .RST_B_I(rst_b), .BOOT_STRAP_I(boot_s), .ROLE_STRAP_I(role_s),
    .BASE_STRAP_I(base_s), .BUS_RST_B_I(brst_b), .PROM_DONE_I(done), .LOCAL_BUS_FLOAT_O(lflt),
    .PROM_BUS_FLOAT_O(pflt), .BOOT_LOCAL_O(blocal), .BOOT_BUS_O(bbus), .BOOT_RESERVED_O(bres),
    .SATELLITE_O(sat), .REG_BASE_O(base), .CPU_CFG_WR_EN_O(wren), .PROM_LOAD_O(load),
    .CFG_READY_O(ready), .BUS_LOGIC_RST_O(blrst), .WARM_RST_O(warm), .CPU_RUN_O(run));
  // ==========
  // helpers
  function automatic logic [16:0] lfsr_next(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1("cfg_ready", 1'b1, ready);
  endtask
  task automatic chk_cfg();
    chk1("boot_local", e_boot == BOOT_LOCAL, blocal);
    chk1("boot_bus", e_boot == BOOT_BUS && e_sat, bbus);
    chk1("boot_reserved", e_boot == BOOT_RESERVED, bres);
    chk1("satellite", e_sat, sat);
    chk32("reg_base", e_base, base);
    chk1("cpu_cfg_wr", !e_sat, wren);
    chk1("local_float", 1'b0, lflt);
    chk1("prom_float", 1'b0, pflt);
    chk1("bus_logic_rst_off", 1'b0, blrst);
    chk1("warm_rst_off", 1'b0, warm);
    chk1("cpu_run", 1'b1, run);
  endtask
  // ==========
  // one cold reset, capture, strap change and bus reset
  task automatic run_case(input logic [1:0] b, input logic r, input logic bad);
    rnd = lfsr_next(rnd);
    e_boot = b;
    e_sat = (b == BOOT_BUS && !bad) ? ROLE_SATELLITE : r;
    e_base = (rnd[0] && b != BOOT_BUS) ? REG_BASE_ALT : REG_BASE_STD;
    @(posedge clk);
    rst_b <= 1'b0;
    boot_q <= b;
    role_q <= r;
    bad_q <= bad;
    base_q <= rnd[0];
    dly_q <= rnd[4:1];
    // cold reset hold kept short so the run stays small
    repeat (5) @(posedge clk);
    #1;
    chk1("local_float_rst", b == BOOT_FLOAT, lflt);
    chk1("prom_float_rst", b == BOOT_FLOAT, pflt);
    chk32("reg_base_rst", REG_BASE_STD, base);
    chk1("boot_local_rst", 1'b0, blocal);
    chk1("bus_logic_rst_rst", 1'b1, blrst);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    boot_q <= rnd[6:5];
    role_q <= rnd[7];
    base_q <= ~rnd[0];
    bad_q <= 1'b1;
    #1;
    chk1("prom_load", b == BOOT_BUS && e_sat, load);
    wait_ready();
    chk_cfg();
    @(posedge clk);
    brst_q <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk1("bus_logic_rst", 1'b1, blrst);
    chk1("warm_rst", e_sat, warm);
    chk1("cpu_run_warm", !e_sat, run);
    @(posedge clk);
    brst_q <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    wait_ready();
    chk_cfg();
    $display("case boot=%0d role=%0d done", b, e_sat);
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
      run_case(i[2:1], i[0], i == 2);
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule // crbm_top_tb
`default_nettype wire

// ==== verilog/crbm_strap_capture.sv ====
`timescale 1ns/1ns
`default_nettype none
module crbm_strap_capture
  import crbm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] boot_strap_i,
  input  wire logic       role_strap_i,
  input  wire logic       base_strap_i,
  crbm_cfg_if.capt        cfg
);
  // ==========================================================================
  // three-stage synchronisers on straps
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [1:0] boot_ff;
  logic       role_ff;
  logic       base_ff;
  logic       cold_ff;
  logic [2:0] vld_ff;
  logic       take;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_ff  <= 4'h0;
      s2_ff  <= 4'h0;
      s3_ff  <= 4'h0;
      vld_ff <= 3'h0;
    end
    else
    begin
      s1_ff  <= {base_strap_i, role_strap_i, boot_strap_i};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      vld_ff <= {vld_ff[1:0], 1'h1};
    end
  end

  // ==========================================================================
  // sample straps once cold reset is released; freeze at the first stable sample
  // the stages still hold reset zeros for three edges; compare only once all hold pin samples
  assign take = cold_ff && vld_ff[2] && (s2_ff == s3_ff);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cold_ff <= 1'b1;
    else if (take)
      cold_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      boot_ff <= BOOT_RST;
      role_ff <= ROLE_RST;
      base_ff <= 1'b0;
    end
    else if (take)
    begin
      boot_ff <= s3_ff[1:0];
      role_ff <= s3_ff[2];
      base_ff <= s3_ff[3];
    end
  end

  assign cfg.boot_src    = boot_ff;
  assign cfg.satellite   = role_ff;
  assign cfg.alt_base    = base_ff;
  assign cfg.cold_active = cold_ff;

  // ==========================================================================
  // checks
  stable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !cold_ff |=> $stable(boot_ff) && $stable(role_ff))
    else $error("straps changed after capture");
  capture_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take |=> boot_ff == $past(s3_ff[1:0]) && role_ff == $past(s3_ff[2]) && !cold_ff)
    else $error("strap not latched");
  fill_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !vld_ff[2] |=> cold_ff)
    else $error("strap captured before synchroniser filled");
endmodule : crbm_strap_capture
`default_nettype wire

// ==== verilog/crbm_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module crbm_top
  import crbm_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [1:0]  BOOT_STRAP_I,
  input  wire logic        ROLE_STRAP_I,
  input  wire logic        BASE_STRAP_I,
  input  wire logic        BUS_RST_B_I,
  input  wire logic        PROM_DONE_I,
  output logic             LOCAL_BUS_FLOAT_O,
  output logic             PROM_BUS_FLOAT_O,
  output logic             BOOT_LOCAL_O,
  output logic             BOOT_BUS_O,
  output logic             BOOT_RESERVED_O,
  output logic             SATELLITE_O,
  output logic [31:0]      REG_BASE_O,
  output logic             CPU_CFG_WR_EN_O,
  output logic             PROM_LOAD_O,
  output logic             CFG_READY_O,
  output logic             BUS_LOGIC_RST_O,
  output logic             WARM_RST_O,
  output logic             CPU_RUN_O
);
  crbm_cfg_if cfg ();

  crbm_strap_capture u_capt (
    .clk_i        (CLK_I),
    .rst_b_i      (RST_B_I),
    .boot_strap_i (BOOT_STRAP_I),
    .role_strap_i (ROLE_STRAP_I),
    .base_strap_i (BASE_STRAP_I),
    .cfg          (cfg.capt)
  );

  // ==========================================================================
  // bus reset synchroniser, three stages
  logic br1_ff;
  logic br2_ff;
  logic br3_ff;
  logic bus_rst_ff;

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      // start at the asserted level so no false release shows while the stages refill
      br1_ff     <= 1'b1;
      br2_ff     <= 1'b1;
      br3_ff     <= 1'b1;
      bus_rst_ff <= 1'b1;
    end
    else
    begin
      br1_ff <= ~BUS_RST_B_I;
      br2_ff <= br1_ff;
      br3_ff <= br2_ff;
      if (br2_ff == br3_ff)
        bus_rst_ff <= br3_ff;
    end
  end

  // ==========================================================================
  // decoded outputs, registered
  logic        float_ff;
  logic        local_ff;
  logic        busb_ff;
  logic        resv_ff;
  logic        sat_ff;
  logic [31:0] base_ff;
  logic        wr_en_ff;
  logic        warm_ff;
  logic        bus_boot;

  // bus boot counts only with the satellite role; nothing decodes before capture
  assign bus_boot = !cfg.cold_active && (cfg.boot_src == BOOT_BUS) && cfg.satellite;

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      float_ff <= 1'b1;
      local_ff <= 1'b0;
      busb_ff  <= 1'b0;
      resv_ff  <= 1'b0;
      sat_ff   <= ROLE_RST;
      base_ff  <= REG_BASE_STD;
      wr_en_ff <= 1'b0;
      warm_ff  <= 1'b0;
    end
    else
    begin
      float_ff <= cfg.cold_active;
      local_ff <= !cfg.cold_active && (cfg.boot_src == BOOT_LOCAL);
      busb_ff  <= bus_boot;
      resv_ff  <= !cfg.cold_active && (cfg.boot_src == BOOT_RESERVED);
      sat_ff   <= cfg.satellite;
      base_ff  <= (cfg.alt_base && (cfg.boot_src != BOOT_BUS)) ? REG_BASE_ALT : REG_BASE_STD;
      wr_en_ff <= !cfg.cold_active && (cfg.satellite == ROLE_HOST);
      warm_ff  <= bus_rst_ff && (cfg.satellite == ROLE_SATELLITE);
    end
  end

  // ==========================================================================
  // configuration load sequence
  crbm_state_e state_ff;
  crbm_state_e nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CRBM_IDLE:
        if (!cfg.cold_active && !bus_rst_ff)
          nxt_state = bus_boot ? CRBM_LOAD : CRBM_DONE;
      CRBM_LOAD:
        if (PROM_DONE_I)
          nxt_state = CRBM_DONE;
      CRBM_DONE:
        nxt_state = CRBM_DONE;
      default:
        nxt_state = CRBM_IDLE;
    endcase
    if (bus_rst_ff && sat_ff)
      nxt_state = CRBM_IDLE;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      state_ff <= CRBM_IDLE;
    else
      state_ff <= nxt_state;
  end

  // only the boot source 11 floats the buses; while cold reset holds every flop the pin is read directly
  logic float_strap;
  assign float_strap       = (BOOT_STRAP_I == BOOT_FLOAT) || (cfg.boot_src == BOOT_FLOAT);
  assign LOCAL_BUS_FLOAT_O = float_strap && (!RST_B_I || (float_ff && cfg.cold_active));
  assign PROM_BUS_FLOAT_O  = LOCAL_BUS_FLOAT_O;
  assign BOOT_LOCAL_O      = local_ff;
  assign BOOT_BUS_O        = busb_ff;
  assign BOOT_RESERVED_O   = resv_ff;
  assign SATELLITE_O       = sat_ff;
  assign REG_BASE_O        = base_ff;
  assign CPU_CFG_WR_EN_O   = wr_en_ff;
  assign PROM_LOAD_O       = (state_ff == CRBM_LOAD);
  assign CFG_READY_O       = (state_ff == CRBM_DONE);
  assign BUS_LOGIC_RST_O   = bus_rst_ff;
  assign WARM_RST_O        = warm_ff;
  assign CPU_RUN_O         = (state_ff == CRBM_DONE) && !warm_ff;

  // ==========================================================================
  // checks
  sequence sat_bus_rst_s;
    bus_rst_ff && sat_ff;
  endsequence

  sequence load_start_s;
    (state_ff == CRBM_IDLE) && !cfg.cold_active && !bus_rst_ff;
  endsequence

  sequence load_end_s;
    (state_ff == CRBM_LOAD) && PROM_DONE_I && !bus_rst_ff;
  endsequence

  warm_host_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !sat_ff && !cfg.satellite |-> !warm_ff)
    else $error("warm reset in host role");

  warm_sat_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    bus_rst_ff && cfg.satellite |=> warm_ff)
    else $error("no warm reset in satellite role");

  warm_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !bus_rst_ff |=> !warm_ff)
    else $error("warm reset without bus reset");

  host_bus_rst_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    bus_rst_ff && !sat_ff && state_ff == CRBM_DONE |=> state_ff == CRBM_DONE)
    else $error("bus reset restarted device in host role");

  host_wr_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    wr_en_ff |-> !sat_ff || $past(cfg.satellite) == ROLE_HOST)
    else $error("cpu write in satellite role");

  wr_en_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !cfg.cold_active && cfg.satellite == ROLE_HOST |=> wr_en_ff)
    else $error("cpu write not granted in host role");

  prom_load_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    state_ff == CRBM_LOAD |-> busb_ff)
    else $error("prom load without bus boot");

  load_end_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    load_end_s |=> state_ff == CRBM_DONE)
    else $error("prom load did not finish");

  bus_boot_load_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    load_start_s ##0 bus_boot |=> state_ff == CRBM_LOAD)
    else $error("bus boot did not start prom load");

  local_done_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    load_start_s ##0 !bus_boot |=> state_ff == CRBM_DONE)
    else $error("local boot did not go ready");

  bus_rst_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    sat_bus_rst_s |=> state_ff == CRBM_IDLE)
    else $error("satellite bus reset did not restart load");

  base_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    base_ff != REG_BASE_STD |-> base_ff == REG_BASE_ALT)
    else $error("bad register base");

  local_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ##1 local_ff |-> $past(cfg.boot_src) == BOOT_LOCAL)
    else $error("local boot misdecoded");

  decode_quiet_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    cfg.cold_active |=> !local_ff && !busb_ff && !resv_ff)
    else $error("boot decode before capture");

  decode_onehot_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $onehot0({local_ff, busb_ff, resv_ff}))
    else $error("more than one boot source decoded");

  reserved_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !cfg.cold_active && cfg.boot_src == BOOT_RESERVED |=> resv_ff)
    else $error("reserved boot source not flagged");

  float_after_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !cfg.cold_active |-> !LOCAL_BUS_FLOAT_O && !PROM_BUS_FLOAT_O)
    else $error("buses float after capture");
endmodule : crbm_top
`default_nettype wire
